// ### bench/tb.sv
// Self-checking testbench for the TX control register block.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("ERROR at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic                i_mclk = 1'b0, i_rst = 1'b1, i_read = 1'b0, i_write = 1'b0;
  logic                strap = 1'b0, go = 1'b0, full = 1'b0;
  logic [7:0]          i_address = 8'h00;
  logic [31:0]         i_writedata = 32'h0;
  logic [3:0]          i_byteenable = 4'hf;
  logic [31:0]         o_readdata, exp_q[$];
  logic                o_waitrequest, o_tx_run, o_status_ptr_clr, o_data_ptr_clr;
  logic                o_must_be_one, o_irq, frame_active, status_full;
  txc_pkg::txc_split_t o_split;
  int                  errors = 0, check_count = 0, cycles = 0, sclr = 0, dclr = 0;
  int                  seed = 32'h52cd, szs[3] = '{2, 14, 0};
  always #50 i_mclk = ~i_mclk;
  txc_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .i_strap_pin(strap), .i_status_full(status_full), .i_frame_active(frame_active),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_tx_run(o_tx_run),
    .o_status_ptr_clr(o_status_ptr_clr), .o_data_ptr_clr(o_data_ptr_clr),
    .o_must_be_one(o_must_be_one), .o_split(o_split), .o_irq(o_irq));
  txc_tx_model far (.i_mclk(i_mclk), .i_rst(i_rst), .i_run(o_tx_run), .i_go(go),
    .i_len(4'hf), .i_full(full), .o_frame(frame_active), .o_full(status_full));
  task automatic stop_test;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // Read data is compared against the oldest expectation in the cycle it stands.
  always @(negedge i_mclk) begin
    sclr += int'(o_status_ptr_clr);
    dclr += int'(o_data_ptr_clr);
    if (i_read && o_waitrequest === 1'b0) begin
      `CHK(o_readdata, exp_q.pop_front())
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= ~wr;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  initial begin
    szs[2] = 3 + int'($unsigned($random(seed)) % 11);
    strap = szs[2][0];
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    tick(4);
    `CHK(o_split, {16'h1200, 16'h0200, 16'h2c00})
    `CHK(o_must_be_one, 1'b0)
    rd(8'h70, 32'h0);
    rd(8'h74, {7'h0, strap, 3'h0, 1'b0, 4'h5, 16'h0});
    rd(8'h80, 32'h0);
    $display("Reset test done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h74, {7'h0, ~strap, 3'h0, 1'b1, 4'(szs[i]), 16'h0});
      tick(2);
      `CHK(o_split, {16'(szs[i] * 1024 - 512), 16'h0200, 16'(16384 - szs[i] * 1024)})
      `CHK(o_must_be_one, 1'b1)
      rd(8'h74, {7'h0, strap, 3'h0, 1'b1, 4'(szs[i]), 16'h0});
    end
    $display("Partition test done");
    wr(8'h7c, 32'hc);
    wr(8'h70, 32'h0000_8000);
    tick(4);
    `CHK(sclr, 1)
    `CHK(dclr, 0)
    wr(8'h70, 32'h0000_4000);
    tick(4);
    `CHK(dclr, 1)
    wr(8'h70, 32'h0);
    tick(4);
    `CHK(sclr + dclr, 2)
    `CHK(o_irq, 1'b1)
    wr(8'h78, 32'hc);
    tick(2);
    `CHK(o_irq, 1'b0)
    rd(8'h70, 32'h0);
    $display("Flush test done");
    wr(8'h7c, 32'h3);
    wr(8'h70, 32'h2);
    tick(3);
    `CHK(o_tx_run, 1'b1)
    full <= 1'b1;
    tick(3);
    `CHK(o_tx_run, 1'b0)
    `CHK(o_irq, 1'b1)
    full <= 1'b0;
    wr(8'h78, 32'h1);
    wr(8'h70, 32'h6);
    full <= 1'b1;
    tick(3);
    `CHK(o_tx_run, 1'b1)
    `CHK(o_irq, 1'b1)
    full <= 1'b0;
    wr(8'h78, 32'h1);
    $display("Suspend test done");
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    wr(8'h70, 32'h7);
    wr(8'h70, 32'h6);
    rd(8'h70, 32'h7);
    `CHK(frame_active, 1'b1)
    while (o_tx_run === 1'b1) @(negedge i_mclk);
    `CHK(frame_active, 1'b0)
    rd(8'h70, 32'h4);
    tick(2);
    `CHK(o_irq, 1'b1)
    $display("Stop test done");
    stop_test();
  end
endmodule

// ### bench/txc_tx_model.sv
// Behavioural transmitter that plays frames and reports status FIFO fullness.
`timescale 1ns/10ps
module txc_tx_model (
  input  wire logic       i_mclk, // Device clock
  input  wire logic       i_rst,  // Synchronous reset
  input  wire logic       i_run,  // Transmitter enabled
  input  wire logic       i_go,   // Start one frame
  input  wire logic [3:0] i_len,  // Frame length in pairs of cycles
  input  wire logic       i_full, // Status FIFO full request
  output logic            o_frame, // Frame in progress
  output logic            o_full  // Status FIFO full level
);
  logic [4:0] left_reg;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      left_reg <= 5'h00;
    end else if (i_go && i_run) begin
      left_reg <= {i_len, 1'b0};
    end else if (left_reg != 5'h00) begin
      left_reg <= left_reg - 5'h01;
    end
  end
  assign o_frame = (left_reg != 5'h00);
  assign o_full  = i_full;
endmodule

// ### logic/txc_pkg.sv
// Package with register map, field positions, reset values and carrier types for the TX control block.
package txc_pkg;

  localparam logic [7:0]  TRANSMIT_CONTROL_OFS       = 8'h70;
  localparam logic [7:0]  HARDWARE_CONFIGURATION_OFS = 8'h74;
  localparam logic [7:0]  IRQ_STATUS_OFS             = 8'h78;
  localparam logic [7:0]  IRQ_MASK_OFS               = 8'h7c;
  localparam logic [7:0]  FIFO_SPLIT_OFS             = 8'h80;

  localparam int TXC_STOP_BIT     = 0;
  localparam int TXC_ENABLE_BIT   = 1;
  localparam int TXC_SOA_BIT      = 2;
  localparam int TXC_DFLUSH_BIT   = 14;
  localparam int TXC_SFLUSH_BIT   = 15;
  localparam int HWC_SIZE_LSB     = 16;
  localparam int HWC_MBO_BIT      = 20;
  localparam int HWC_STRAP_BIT    = 24;

  localparam int IRQ_SFULL_BIT    = 0;
  localparam int IRQ_STOPPED_BIT  = 1;
  localparam int IRQ_SFLUSH_BIT   = 2;
  localparam int IRQ_DFLUSH_BIT   = 3;
  localparam int IRQ_W            = 4;

  localparam logic [3:0]  TX_SIZE_RESET   = 4'h5;
  localparam logic [3:0]  TX_SIZE_MAX_KB  = 4'he;
  localparam logic [15:0] TOTAL_BYTES     = 16'h4000;
  localparam logic [15:0] STATUS_BYTES    = 16'h0200;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  typedef struct packed {
    logic sflush;
    logic dflush;
    logic stop;
    logic overrun_allow;
    logic enable;
  } txc_ctrl_t;

  typedef struct packed {
    logic [15:0] tx_data_bytes;
    logic [15:0] tx_status_bytes;
    logic [15:0] rx_bytes;
  } txc_split_t;

  typedef enum logic [2:0] {
    TXC_IDLE    = 3'b001,
    TXC_RUN     = 3'b010,
    TXC_DRAIN   = 3'b100
  } txc_state_t;

endpackage

// ### logic/txc_top.sv
// Transmit control and FIFO partition register block on an Avalon-MM slave.
`timescale 1ns/10ps
// Overview of operation
// - Writing one to the status flush bit clears the TX status FIFO pointers.
// - Writing one to the data flush bit clears the TX data FIFO pointers.
// - With overrun allow clear, a full status FIFO suspends transmission.
// - Overrun allow never changes the status FIFO full interrupt.
// - With the enable bit set the transmitter sends pending FIFO data.
// - The enable bit clears itself once stop was requested and transmitter halted.
// - A stop request lets the current frame finish before transmission ceases.
// - The stop bit self-clears on halt; writes are ignored while it reads one.
// - A read-only bit reports the sampled crossover strap level.
// - The TX FIFO size field, bits 16 to 19, counts kilobytes, resets to 5.
// - The status FIFO takes 512 bytes; the rest forms the data FIFO.
// - The data FIFO holds both command words and payload data.
// - The receive FIFOs get 16KB minus the transmit allocation.
module txc_top (
  input  wire logic        i_mclk,           // 10 MHz clock
  input  wire logic        i_rst,            // Synchronous reset, active high
  input  wire logic [7:0]  i_address,        // Avalon byte address
  input  wire logic        i_read,           // Avalon read request
  input  wire logic        i_write,          // Avalon write request
  input  wire logic [31:0] i_writedata,      // Avalon write data
  input  wire logic [3:0]  i_byteenable,     // Avalon byte enables
  input  wire logic        i_strap_pin,      // Crossover strap pin, asynchronous
  input  wire logic        i_status_full,    // TX status FIFO full
  input  wire logic        i_frame_active,   // Transmitter is inside a frame
  output logic [31:0]      o_readdata,       // Avalon read data
  output logic             o_waitrequest,    // Avalon wait request
  output logic             o_tx_run,         // Transmitter may send FIFO data
  output logic             o_status_ptr_clr, // One-cycle TX status pointer reset
  output logic             o_data_ptr_clr,   // One-cycle TX data pointer reset
  output logic             o_must_be_one,    // Must-be-one bit for device logic
  output txc_pkg::txc_split_t o_split,       // Byte sizes of the FIFO partitions
  output logic             o_irq             // Level interrupt
);

  logic                  ack_reg;
  logic                  strap_s1_reg;
  logic                  strap_s2_reg;
  logic                  strap_reg;
  logic                  strap_taken_reg;
  logic [1:0]            strap_fill_reg;
  txc_pkg::txc_ctrl_t    ctrl_reg;
  txc_pkg::txc_state_t   state_reg;
  logic [3:0]            size_reg;
  logic                  mbo_reg;
  logic [txc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [txc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [txc_pkg::IRQ_W-1:0] irq_event;
  logic                  sfull_d_reg;
  logic                  halted;
  logic                  wr_take;
  logic                  rd_take;
  logic [15:0]           tx_bytes;

  // A request is taken at the edge where waitrequest is seen low.
  assign wr_take = i_write & ack_reg;
  assign rd_take = i_read & ack_reg;

  // One wait state per access: waitrequest drops for one cycle then rises.
  // Waitrequest has its own flop and always holds the inverse of the acknowledge.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_reg       <= 1'b0;
      o_waitrequest <= 1'b1;
    end else begin
      ack_reg       <= (i_read | i_write) & ~ack_reg;
      o_waitrequest <= ~((i_read | i_write) & ~ack_reg);
    end
  end

  // Strap synchroniser; the level is caught once both stages hold the pin.
  // The fill marker keeps the reset value of the second stage from being latched.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      strap_s1_reg   <= 1'b0;
      strap_s2_reg   <= 1'b0;
      strap_fill_reg <= 2'b00;
    end else begin
      strap_s1_reg   <= i_strap_pin;
      strap_s2_reg   <= strap_s1_reg;
      strap_fill_reg <= {strap_fill_reg[0], 1'b1};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      strap_reg       <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (strap_fill_reg[1] && !strap_taken_reg) begin
      strap_reg       <= strap_s2_reg;
      strap_taken_reg <= 1'b1;
    end
  end

  // Halted means the stop request is pending, no frame is in flight and the state is not run.
  // A stop written while idle completes as well, so the stop bit cannot stick.
  assign halted = ctrl_reg.stop & ~i_frame_active & (state_reg != txc_pkg::TXC_RUN);

  // Transmitter state: run, then drain the current frame after a stop.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= txc_pkg::TXC_IDLE;
    end else begin
      unique case (state_reg)
        txc_pkg::TXC_IDLE: begin
          if (ctrl_reg.enable && !ctrl_reg.stop) begin
            state_reg <= txc_pkg::TXC_RUN;
          end
        end
        txc_pkg::TXC_RUN: begin
          if (ctrl_reg.stop) begin
            state_reg <= txc_pkg::TXC_DRAIN;
          end else if (!ctrl_reg.enable) begin
            state_reg <= txc_pkg::TXC_IDLE;
          end
        end
        txc_pkg::TXC_DRAIN: begin
          if (halted) begin
            state_reg <= txc_pkg::TXC_IDLE;
          end
        end
      endcase
    end
  end

  // Transmit control register writes and self-clearing bits.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg.sflush <= 1'b0;
      ctrl_reg.dflush <= 1'b0;
      if (wr_take && i_address == txc_pkg::TRANSMIT_CONTROL_OFS) begin
        if (i_byteenable[1]) begin
          ctrl_reg.sflush <= i_writedata[txc_pkg::TXC_SFLUSH_BIT];
          ctrl_reg.dflush <= i_writedata[txc_pkg::TXC_DFLUSH_BIT];
        end
        if (i_byteenable[0]) begin
          ctrl_reg.overrun_allow <= i_writedata[txc_pkg::TXC_SOA_BIT];
          ctrl_reg.enable        <= i_writedata[txc_pkg::TXC_ENABLE_BIT];
          if (!ctrl_reg.stop && i_writedata[txc_pkg::TXC_STOP_BIT]) begin
            ctrl_reg.stop <= 1'b1;
          end
        end
      end
      if (halted) begin
        ctrl_reg.stop   <= 1'b0;
        ctrl_reg.enable <= 1'b0;
      end
    end
  end

  // Hardware configuration register; host writes are taken in any transmitter state.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      size_reg <= txc_pkg::TX_SIZE_RESET;
      mbo_reg  <= 1'b0;
    end else if (wr_take && i_address == txc_pkg::HARDWARE_CONFIGURATION_OFS
                 && i_byteenable[2]) begin
      size_reg <= i_writedata[txc_pkg::HWC_SIZE_LSB +: 4];
      mbo_reg  <= i_writedata[txc_pkg::HWC_MBO_BIT];
    end
  end

  assign tx_bytes = {2'b00, size_reg, 10'h000};

  // Partition outputs registered from the size field.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_split <= '0;
    end else begin
      o_split.tx_status_bytes <= txc_pkg::STATUS_BYTES;
      o_split.tx_data_bytes   <= tx_bytes - txc_pkg::STATUS_BYTES;
      o_split.rx_bytes        <= txc_pkg::TOTAL_BYTES - tx_bytes;
    end
  end

  // Outputs toward the transmit engine and FIFOs.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tx_run         <= 1'b0;
      o_status_ptr_clr <= 1'b0;
      o_data_ptr_clr   <= 1'b0;
      o_must_be_one    <= 1'b0;
    end else begin
      o_tx_run <= (state_reg != txc_pkg::TXC_IDLE) & ~halted
                  & (ctrl_reg.overrun_allow | ~i_status_full);
      o_status_ptr_clr <= ctrl_reg.sflush;
      o_data_ptr_clr   <= ctrl_reg.dflush;
      o_must_be_one    <= mbo_reg;
    end
  end

  // Interrupt events; the full event ignores the overrun allow setting.
  always_comb begin
    irq_event = '0;
    irq_event[txc_pkg::IRQ_SFULL_BIT]   = i_status_full & ~sfull_d_reg;
    irq_event[txc_pkg::IRQ_STOPPED_BIT] = halted;
    irq_event[txc_pkg::IRQ_SFLUSH_BIT]  = ctrl_reg.sflush;
    irq_event[txc_pkg::IRQ_DFLUSH_BIT]  = ctrl_reg.dflush;
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sfull_d_reg    <= 1'b0;
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
    end else begin
      sfull_d_reg <= i_status_full;
      if (wr_take && i_address == txc_pkg::IRQ_STATUS_OFS) begin
        irq_status_reg <= (irq_status_reg & ~i_writedata[txc_pkg::IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
      if (wr_take && i_address == txc_pkg::IRQ_MASK_OFS && i_byteenable[0]) begin
        irq_mask_reg <= i_writedata[txc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data; unmapped addresses read zero.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_readdata <= '0;
    end else if (rd_take || !i_read) begin
      o_readdata <= txc_pkg::UNMAPPED_READ;
    end else begin
      unique case (i_address)
        txc_pkg::TRANSMIT_CONTROL_OFS: begin
          o_readdata <= {16'h0000, ctrl_reg.sflush, ctrl_reg.dflush, 11'h000,
                         ctrl_reg.overrun_allow, ctrl_reg.enable, ctrl_reg.stop};
        end
        txc_pkg::HARDWARE_CONFIGURATION_OFS: begin
          o_readdata <= {7'h00, strap_reg, 3'h0, mbo_reg, size_reg, 16'h0000};
        end
        txc_pkg::IRQ_STATUS_OFS: begin
          o_readdata <= {28'h0000000, irq_status_reg};
        end
        txc_pkg::IRQ_MASK_OFS: begin
          o_readdata <= {28'h0000000, irq_mask_reg};
        end
        default: begin
          o_readdata <= txc_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  stop_clears_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    halted |=> !ctrl_reg.stop && !ctrl_reg.enable)
    else $error("stop or enable not cleared after halt");
  frame_finish_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ctrl_reg.stop && i_frame_active) |=> ctrl_reg.stop)
    else $error("stop cleared during active frame");
  stop_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ctrl_reg.stop && !halted) |=> ctrl_reg.stop)
    else $error("stop bit changed before the transmitter halted");
  suspend_full_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_status_full && !ctrl_reg.overrun_allow) |=> !o_tx_run)
    else $error("transmit ran with full status fifo");
  run_enable_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_reg == txc_pkg::TXC_RUN && ctrl_reg.enable && !i_status_full) |=> o_tx_run)
    else $error("transmitter not running while enabled");
  sflush_pulse_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_take && i_address == txc_pkg::TRANSMIT_CONTROL_OFS && i_byteenable[1]
     && i_writedata[txc_pkg::TXC_SFLUSH_BIT]) |=> ##1 o_status_ptr_clr ##1 !o_status_ptr_clr)
    else $error("status flush pulse wrong");
  dflush_pulse_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_take && i_address == txc_pkg::TRANSMIT_CONTROL_OFS && i_byteenable[1]
     && i_writedata[txc_pkg::TXC_DFLUSH_BIT]) |=> ##1 o_data_ptr_clr ##1 !o_data_ptr_clr)
    else $error("data flush pulse wrong");
  full_irq_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_status_full && !sfull_d_reg) |=> irq_status_reg[txc_pkg::IRQ_SFULL_BIT])
    else $error("full event not latched");
  rx_split_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !$past(i_rst) |-> (o_split.rx_bytes + o_split.tx_data_bytes + o_split.tx_status_bytes
                       == txc_pkg::TOTAL_BYTES))
    else $error("fifo split does not add to total");

  stop_drain_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    state_reg == txc_pkg::TXC_DRAIN ##[1:20] halted);
  suspend_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_tx_run ##1 !o_tx_run && i_status_full);
  irq_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_irq);
  flush_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_status_ptr_clr ##[1:20] o_data_ptr_clr);
  full_allow_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    i_status_full && ctrl_reg.overrun_allow && o_tx_run);

endmodule
